// [core/atsb_defs.vh]
// Constants for the addressed two-line serial bus channel.
// Assumes inclusion by the channel modules; definitions only.
`ifndef ATSB_DEFS_VH
`define ATSB_DEFS_VH
// Register addresses on the plain register port
`define ATSB_ADDR_SHIFT 3'h0
`define ATSB_ADDR_MODE 3'h1
`define ATSB_ADDR_SLAVE 3'h2
`define ATSB_ADDR_BUSCTRL 3'h3
`define ATSB_ADDR_PORT 3'h4
// Mode register bit positions
`define ATSB_MODE_EN 7
`define ATSB_MODE_MATCH 6
`define ATSB_MODE_WUP 5
`define ATSB_MODE_LINESEL 0
// Bus control register bit positions
`define ATSB_BC_RELEASE_TRIGGER 0
`define ATSB_BC_COMMAND_TRIGGER 1
`define ATSB_BC_RELEASE_DETECTED 2
`define ATSB_BC_COMMAND_DETECTED 3
`define ATSB_BC_ACK_DETECTED 6
`define ATSB_BC_XFER 7
// Port register bit positions
`define ATSB_PORT_LATCH_A 0
`define ATSB_PORT_LATCH_B 1
`define ATSB_PORT_DIR_A 2
`define ATSB_PORT_DIR_B 3
// Reset values
`define ATSB_RST_BYTE 8'h00
`define ATSB_RST_PORT 8'h0C
// Bits per transfer and clock count of the flag edge
`define ATSB_BITS 4'h8
`define ATSB_FLAG_CLK 4'h9
`endif

// [core/atsb_sync.v]
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs come from outside the clk domain.
`timescale 1ns/100ps
module atsb_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Raw and synchronised levels
  input wire [WIDTH-1:0] rawIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else begin
      stage1 <= rawIn;
      syncOut <= stage1;
    end
  end
endmodule // atsb_sync

// [core/atsb_edge.v]
// Edge finder on a synchronised level.
// Assumes its input is already in the clk domain.
`timescale 1ns/100ps
module atsb_edge (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Level in, edge pulses out
  input wire level,
  output wire rise,
  output wire fall,
  output reg prev
);
  // Previous level for comparison
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b1;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule // atsb_edge

// [core/atsb_channel.v]
// Addressed two-line serial bus channel, slave-clocked device end.
// Assumes an external master drives the serial clock line and that
// both data lines are open drain with a pull-up outside.
// Function
// - Shift register captures real bus level
// - Match flag compares slave address, shift
// - Output bit set on falling clock, MSB first out
// - Sample data line on rising clock
// - Master addresses a slave before commands
// - Write starts transfer only when enabled, idle
// - Enabling after write does not start transfer
// - Wake-up select keeps data output released
// - Busy write retained until line is ready
// - Stop after eight bits, set transfer flag
// - Data change with clock high decoded
// - Rise sets release, fall sets command
// - Ninth clock flag, address gated under wake-up
// - Low on ninth clock is acknowledge
`timescale 1ns/100ps
`include "atsb_defs.vh"
module atsb_channel #(
  parameter BITS = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  // Serial clock line input
  input wire serialClkLine,
  // Data bus line a, open drain
  input wire dataBusLineAIn,
  output wire dataBusLineAOut,
  output wire dataBusLineAOe,
  // Data bus line b, open drain
  input wire dataBusLineBIn,
  output wire dataBusLineBOut,
  output wire dataBusLineBOe,
  // Transfer interrupt request
  output wire xferIrq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SHIFT = 2'h2;
  localparam ST_TAIL = 2'h3;

  reg [1:0] state;
  reg [7:0] serialShiftReg;
  reg [7:0] slaveAddrReg;
  reg channelEnableBit;
  reg wakeupSelect;
  reg lineSel;
  reg txOutputLatch;
  reg releaseDetected;
  reg commandDetected;
  reg ackDetected;
  reg xferIrqFlag;
  reg portLatchA;
  reg portLatchB;
  reg portDirBitA;
  reg portDirBitB;
  reg addrPending;
  reg [3:0] bitCount;
  wire [2:0] syncLines;
  wire sclk;
  wire sdaA;
  wire sdaB;
  wire sda;
  wire sclkRise;
  wire sclkFall;
  wire sclkPrev;
  wire sdaRise;
  wire sdaFall;
  wire sdaPrev;
  wire addrMatchFlag;
  wire shiftWrite;
  wire lineIdle;
  wire txDrive;
  wire [7:0] modeRead;
  wire [7:0] busCtrlRead;
  wire [7:0] portRead;

  // Pins pass two flip-flops before use
  atsb_sync #(
    .WIDTH(3)
  ) uSync (
    .clk(clk),
    .rst(rst),
    .rawIn({serialClkLine, dataBusLineBIn, dataBusLineAIn}),
    .syncOut(syncLines)
  );

  assign sclk = syncLines[2];
  assign sdaB = syncLines[1];
  assign sdaA = syncLines[0];
  assign sda = lineSel ? sdaB : sdaA;

  // Serial clock edges
  atsb_edge uClkEdge (
    .clk(clk),
    .rst(rst),
    .level(sclk),
    .rise(sclkRise),
    .fall(sclkFall),
    .prev(sclkPrev)
  );

  // Selected data line edges
  atsb_edge uDataEdge (
    .clk(clk),
    .rst(rst),
    .level(sda),
    .rise(sdaRise),
    .fall(sdaFall),
    .prev(sdaPrev)
  );

  // Comparator, forced low while disabled
  assign addrMatchFlag = channelEnableBit & (slaveAddrReg == serialShiftReg);
  assign shiftWrite = regWr && (regAddr == `ATSB_ADDR_SHIFT);
  // Idle whenever the serial clock is high
  assign lineIdle = sclk;
  assign xferIrq = xferIrqFlag;

  // Register writes and mode bits
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      slaveAddrReg <= `ATSB_RST_BYTE;
      channelEnableBit <= 1'b0;
      wakeupSelect <= 1'b0;
      lineSel <= 1'b0;
      portLatchA <= 1'b0;
      portLatchB <= 1'b0;
      portDirBitA <= 1'b1;
      portDirBitB <= 1'b1;
    end else if (regWr) begin
      if (regAddr == `ATSB_ADDR_MODE) begin
        channelEnableBit <= regWrData[`ATSB_MODE_EN];
        wakeupSelect <= regWrData[`ATSB_MODE_WUP];
        lineSel <= regWrData[`ATSB_MODE_LINESEL];
      end else if (regAddr == `ATSB_ADDR_SLAVE) begin
        slaveAddrReg <= regWrData;
      end else if (regAddr == `ATSB_ADDR_PORT) begin
        portLatchA <= regWrData[`ATSB_PORT_LATCH_A];
        portLatchB <= regWrData[`ATSB_PORT_LATCH_B];
        portDirBitA <= regWrData[`ATSB_PORT_DIR_A];
        portDirBitB <= regWrData[`ATSB_PORT_DIR_B];
      end
    end
  end

  // Transfer engine, shift register and output latch
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      serialShiftReg <= `ATSB_RST_BYTE;
      txOutputLatch <= 1'b1;
      bitCount <= 4'h0;
    end else if (!channelEnableBit) begin
      state <= ST_IDLE;
      txOutputLatch <= 1'b1;
      bitCount <= 4'h0;
      if (shiftWrite) begin
        serialShiftReg <= regWrData;
      end
    end else begin
      // Bus control triggers drive the output latch between bytes
      if (regWr && (regAddr == `ATSB_ADDR_BUSCTRL) && state == ST_IDLE) begin
        if (regWrData[`ATSB_BC_RELEASE_TRIGGER]) begin
          txOutputLatch <= 1'b1;
        end else if (regWrData[`ATSB_BC_COMMAND_TRIGGER]) begin
          txOutputLatch <= 1'b0;
        end
      end
      case (state)
        ST_IDLE: begin
          if (shiftWrite) begin
            serialShiftReg <= regWrData;
            bitCount <= 4'h0;
            state <= (lineIdle && sda) ? ST_SHIFT : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (shiftWrite) begin
            serialShiftReg <= regWrData;
          end else if (sda && sclk) begin
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (sclkFall) begin
            txOutputLatch <= serialShiftReg[BITS-1];
          end else if (sclkRise) begin
            serialShiftReg <= {serialShiftReg[BITS-2:0], sda};
            bitCount <= bitCount + 4'h1;
            if (bitCount == `ATSB_BITS - 4'h1) begin
              state <= ST_TAIL;
            end
          end
        end
        default: begin
          // Release line after eighth bit, wait for ninth clock
          if (sclkFall) begin
            txOutputLatch <= 1'b1;
          end else if (sclkRise) begin
            bitCount <= 4'h0;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Ninth rising clock of a byte
  wire ninthRise = (state == ST_TAIL) && sclkRise && channelEnableBit;
  wire condValid = channelEnableBit && sclk && sclkPrev;

  // Bus condition and status flags; hardware set wins over clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      releaseDetected <= 1'b0;
      commandDetected <= 1'b0;
      ackDetected <= 1'b0;
      xferIrqFlag <= 1'b0;
      addrPending <= 1'b0;
    end else begin
      if (regWr && (regAddr == `ATSB_ADDR_BUSCTRL)) begin
        if (!regWrData[`ATSB_BC_XFER]) begin
          xferIrqFlag <= 1'b0;
        end
        if (!regWrData[`ATSB_BC_ACK_DETECTED]) begin
          ackDetected <= 1'b0;
        end
      end
      if (!channelEnableBit) begin
        releaseDetected <= 1'b0;
        commandDetected <= 1'b0;
        ackDetected <= 1'b0;
        addrPending <= 1'b0;
      end else if (condValid && sdaRise) begin
        releaseDetected <= 1'b1;
        commandDetected <= 1'b0;
        addrPending <= 1'b1;
      end else if (condValid && sdaFall) begin
        commandDetected <= 1'b1;
      end else if (ninthRise) begin
        // Low data on ninth clock is acknowledge
        if (!sda) begin
          ackDetected <= 1'b1;
        end
        addrPending <= 1'b0;
        if (!wakeupSelect) begin
          xferIrqFlag <= 1'b1;
        end else if (addrPending && releaseDetected && commandDetected) begin
          if (addrMatchFlag) begin
            xferIrqFlag <= 1'b1;
          end else begin
            releaseDetected <= 1'b0;
          end
        end
      end
    end
  end

  // Open-drain drive: pull low only when port latch and output latch are both low
  assign txDrive = channelEnableBit && !wakeupSelect && !txOutputLatch;
  assign dataBusLineAOut = 1'b0;
  assign dataBusLineBOut = 1'b0;
  assign dataBusLineAOe = !portDirBitA && !portLatchA && txDrive && !lineSel;
  assign dataBusLineBOe = !portDirBitB && !portLatchB && txDrive && lineSel;

  // Read views of the registers
  assign modeRead = {channelEnableBit, addrMatchFlag, wakeupSelect, 4'h0, lineSel};
  assign busCtrlRead = {xferIrqFlag, ackDetected, 2'h0, commandDetected,
    releaseDetected, 2'h0};
  assign portRead = {4'h0, portDirBitB, portDirBitA, sdaB, sdaA};

  // Read data one cycle after the strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= `ATSB_RST_BYTE;
    end else if (regRd) begin
      if (regAddr == `ATSB_ADDR_SHIFT) begin
        regRdData <= serialShiftReg;
      end else if (regAddr == `ATSB_ADDR_MODE) begin
        regRdData <= modeRead;
      end else if (regAddr == `ATSB_ADDR_SLAVE) begin
        regRdData <= slaveAddrReg;
      end else if (regAddr == `ATSB_ADDR_BUSCTRL) begin
        regRdData <= busCtrlRead;
      end else if (regAddr == `ATSB_ADDR_PORT) begin
        regRdData <= portRead;
      end else begin
        regRdData <= `ATSB_RST_BYTE;
      end
    end
  end
endmodule // atsb_channel

// [tb/atsb_channel_props.sv]
// Port relations of the serial channel.
// Assumes a bind into atsb_channel; sees only its ports.
`timescale 1ns/100ps
`include "atsb_defs.vh"
module atsb_channel_props #(
  parameter BITS = 8
) (
  // Clock, reset, register port
  input wire clk,
  input wire rst,
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdData,
  // Serial lines and flag
  input wire serialClkLine,
  input wire dataBusLineAIn,
  input wire dataBusLineAOut,
  input wire dataBusLineAOe,
  input wire dataBusLineBOut,
  input wire dataBusLineBOe,
  input wire xferIrq
);
  reg [7:0] mode;
  reg [7:0] port;
  reg clkQ;
  reg dataQ;
  reg [3:0] sinceRise;
  reg [3:0] quiet;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow registers; ages of last clock rise and of last drive cause
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= 8'h00;
      port <= 8'h0C;
      clkQ <= 1'b1;
      dataQ <= 1'b1;
      sinceRise <= 4'hF;
      quiet <= 4'hF;
    end else begin
      clkQ <= serialClkLine;
      dataQ <= dataBusLineAIn;
      if (regWr && regAddr == `ATSB_ADDR_MODE)
        mode <= regWrData;
      if (regWr && regAddr == `ATSB_ADDR_PORT)
        port <= regWrData;
      if (serialClkLine && !clkQ)
        sinceRise <= 4'h0;
      else if (sinceRise != 4'hF)
        sinceRise <= sinceRise + 4'h1;
      if (regWr || (clkQ && !serialClkLine) || (dataBusLineAIn && !dataQ))
        quiet <= 4'h0;
      else if (quiet != 4'hF)
        quiet <= quiet + 4'h1;
    end
  end
  sequence sModeRead;
    regRd && regAddr == `ATSB_ADDR_MODE;
  endsequence
  sequence sBlankRead;
    regRd && regAddr > `ATSB_ADDR_PORT;
  endsequence
  AST_OD_LOW: assert property (!dataBusLineAOut && !dataBusLineBOut)
    else $error("data output not low");
  AST_DIR_INPUT: assert property (port[`ATSB_PORT_DIR_A] |-> !dataBusLineAOe)
    else $error("input pin driven");
  AST_WUP_RELEASE: assert property (
    mode[`ATSB_MODE_WUP] |-> !dataBusLineAOe)
    else $error("driven under wake-up");
  AST_STOP_RELEASE: assert property (
    !mode[`ATSB_MODE_EN] |-> !dataBusLineAOe && !dataBusLineBOe)
    else $error("driven while disabled");
  AST_MODE_READ: assert property (
    sModeRead |=> (regRdData & 8'hA1) == ($past(mode) & 8'hA1))
    else $error("mode read wrong");
  AST_BLANK_READ: assert property (sBlankRead |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_FLAG_AT_RISE: assert property ($rose(xferIrq) |-> sinceRise <= 4'h6)
    else $error("flag away from clock rise");
  AST_FLAG_ENABLED: assert property ($rose(xferIrq) |-> mode[`ATSB_MODE_EN])
    else $error("flag while disabled");
  AST_DRIVE_CAUSE: assert property ($rose(dataBusLineAOe) |-> quiet <= 4'h6)
    else $error("drive without cause");
endmodule // atsb_channel_props
bind atsb_channel atsb_channel_props #(.BITS(BITS)) uProps (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .serialClkLine(serialClkLine), .dataBusLineAIn(dataBusLineAIn),
  .dataBusLineAOut(dataBusLineAOut), .dataBusLineAOe(dataBusLineAOe),
  .dataBusLineBOut(dataBusLineBOut), .dataBusLineBOe(dataBusLineBOe), .xferIrq(xferIrq));

// [tb/atsb_master_model.sv]
// Bus master model: serial clock and open-drain pull on line a.
// Assumes the bench forms the wired level and feeds it back.
`timescale 1ns/100ps
module atsb_master_model (
  // Wired data level
  input wire lineIn,
  // Clock and pull
  output reg sclk,
  output reg pull
);
  // Clock idles high and stands still between frames
  initial begin
    sclk = 1'b1;
    pull = 1'b0;
  end
  // Hold or free the line with the clock high
  task setPull(input p);
    pull = p;
  endtask
  // Fall then rise of data with clock high
  task relCond;
    begin
      pull = 1'b1;
      #400 pull = 1'b0;
      #400;
    end
  endtask
  // Fall of data with clock high
  task cmdCond;
    begin
      #400 pull = 1'b1;
      #400;
    end
  endtask
  // Eight bits MSB first, then the ninth clock with optional acknowledge
  task xfer(input [7:0] tx, input ack, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sclk = 1'b0;
        #100 pull = !tx[i];
        #100 sclk = 1'b1;
        #100 rx[i] = lineIn;
        #100;
      end
      sclk = 1'b0;
      #100 pull = ack;
      #100 sclk = 1'b1;
      #300 pull = 1'b0;
      #300;
    end
  endtask
endmodule // atsb_master_model

// [tb/test_atsb_channel.sv]
// Self-checking bench of the serial channel.
// Assumes the channel, its checker and the master model are compiled.
`timescale 1ns/100ps
`include "atsb_defs.vh"
module test_atsb_channel;
  reg clk;
  reg rst;
  reg [2:0] regAddr;
  reg [7:0] regWrData;
  reg regWr;
  reg regRd;
  wire [7:0] regRdData;
  wire sclk;
  wire mPull;
  wire aOe;
  wire bOe;
  wire xferIrq;
  wire lineA = !(aOe || mPull); // Pull-up unless a party pulls
  wire lineB = !bOe;
  integer error_cnt;
  integer checked;
  integer n;
  reg [7:0] d;
  reg [7:0] e;
  reg [7:0] rx;
  reg [7:0] v;
  atsb_channel #(.BITS(8)) DUT (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .serialClkLine(sclk), .dataBusLineAIn(lineA), .dataBusLineAOut(), .dataBusLineAOe(aOe),
    .dataBusLineBIn(lineB), .dataBusLineBOut(), .dataBusLineBOe(bOe), .xferIrq(xferIrq));
  atsb_master_model uMaster (.lineIn(lineA), .sclk(sclk), .pull(mPull));
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  // Register write
  task wr(input [2:0] a, input [7:0] w);
    begin
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= w;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  // Register read, data taken the cycle after the strobe
  task rd(input [2:0] a, output [7:0] r);
    begin
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 r = regRdData;
    end
  endtask
  // Compare and count
  task chk(input [7:0] s, input [7:0] x);
    begin
      checked = checked + 1;
      if (s !== x) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0t got %h want %h", $time, s, x);
      end
    end
  endtask
  // Wired level of two open-drain senders
  function [7:0] wired(input [7:0] a, input [7:0] b);
    wired = a & b;
  endfunction
  // Verdict and end of run
  task complete_run;
    begin
      $display("checked %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    #1000000;
    error_cnt = error_cnt + 1;
    complete_run;
  end
  // Test sequence
  initial begin
    rst = 1'b1;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    error_cnt = 0;
    checked = 0;
    v = $urandom(84);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`ATSB_ADDR_MODE, v);
    chk(v, 8'h00);
    rd(3'h5, v);
    chk(v, 8'h00);
    $display("reset test done");
    wr(`ATSB_ADDR_PORT, 8'h03);
    wr(`ATSB_ADDR_MODE, 8'h80);
    wr(`ATSB_ADDR_BUSCTRL, 8'h01);
    wr(`ATSB_ADDR_PORT, 8'h00);
    wr(`ATSB_ADDR_SLAVE, 8'h5A);
    wr(`ATSB_ADDR_MODE, 8'hA0);
    wr(`ATSB_ADDR_SHIFT, 8'hFF);
    uMaster.relCond;
    uMaster.cmdCond;
    uMaster.xfer(8'h5A, 1'b0, rx);
    chk({7'h0, xferIrq}, 8'h01);
    rd(`ATSB_ADDR_BUSCTRL, v);
    chk(v & 8'h8C, 8'h8C);
    rd(`ATSB_ADDR_SHIFT, v);
    chk(v, 8'h5A);
    rd(`ATSB_ADDR_MODE, v);
    chk(v & 8'h40, 8'h40);
    wr(`ATSB_ADDR_BUSCTRL, 8'h00);
    wr(`ATSB_ADDR_SHIFT, 8'h00);
    e = $urandom;
    if (e == 8'h5A)
      e = 8'h5B;
    uMaster.relCond;
    uMaster.cmdCond;
    uMaster.xfer(e, 1'b0, rx);
    chk({7'h0, xferIrq}, 8'h00);
    chk(rx, e);
    rd(`ATSB_ADDR_BUSCTRL, v);
    chk(v & 8'h84, 8'h00);
    $display("address test done");
    wr(`ATSB_ADDR_MODE, 8'h80);
    for (n = 0; n < 8; n = n + 1) begin
      d = $urandom;
      e = (n < 4) ? 8'hFF : $urandom;
      wr(`ATSB_ADDR_BUSCTRL, 8'h00);
      wr(`ATSB_ADDR_SHIFT, d);
      uMaster.xfer(e, 1'b1, rx);
      chk(rx, wired(d, e));
      chk({7'h0, xferIrq}, 8'h01);
      rd(`ATSB_ADDR_SHIFT, v);
      chk(v, wired(d, e));
      rd(`ATSB_ADDR_BUSCTRL, v);
      chk(v & 8'hC0, 8'hC0);
    end
    $display("transmit test done");
    wr(`ATSB_ADDR_MODE, 8'h00);
    wr(`ATSB_ADDR_BUSCTRL, 8'h00);
    wr(`ATSB_ADDR_SHIFT, 8'h3C);
    wr(`ATSB_ADDR_MODE, 8'h80);
    uMaster.xfer(8'hFF, 1'b0, rx);
    chk({7'h0, xferIrq}, 8'h00);
    chk(rx, 8'hFF);
    $display("enable test done");
    uMaster.setPull(1'b1);
    d = $urandom;
    wr(`ATSB_ADDR_SHIFT, d);
    repeat (20) @(posedge clk);
    rd(`ATSB_ADDR_PORT, v);
    chk(v & 8'h01, 8'h00);
    uMaster.setPull(1'b0);
    #400;
    rd(`ATSB_ADDR_PORT, v);
    chk(v & 8'h01, 8'h01);
    uMaster.xfer(8'hFF, 1'b0, rx);
    chk(rx, d);
    $display("busy test done");
    complete_run;
  end
endmodule // test_atsb_channel
